// ==== ptc_defines.svh ====
/*
 * Constants for the protection and trim configuration bank.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

// Register addresses on the serial register port.
`define PTC_ADDR_ZCD  8'h4D
`define PTC_ADDR_OCL  8'h4E
`define PTC_ADDR_OV   8'h4F
`define PTC_ADDR_UV   8'h50
`define PTC_ADDR_TW   8'h51
`define PTC_ADDR_CLR  8'h52
`define PTC_ADDR_AUX  8'h53

// Implemented-bit masks; reserved bits store nothing and read zero.
`define PTC_MASK_ZCD  8'h3F
`define PTC_MASK_OCL  8'h3F
`define PTC_MASK_OV   8'h07
`define PTC_MASK_UV   8'h07
`define PTC_MASK_TW   8'hFF
`define PTC_MASK_CLR  8'h01
`define PTC_MASK_AUX  8'h0E

// Reset values.
`define PTC_RST_ZERO  8'h00
`define PTC_RST_TW    8'hFF

// Field positions.
`define PTC_OCL_EN    0
`define PTC_CLR_BIT   0
`define PTC_AUX_CURRENT_LIMIT_EVENT  1
`define PTC_AUX_SRC   2
`define PTC_AUX_SONIC 3

// Threshold arithmetic, millivolts.
`define PTC_OCL_BASE  12'h0D7
`define PTC_OCL_STEP  12'h023
`define PTC_OV_NOM    12'h258
`define PTC_OV_CLAMP  12'h7D0
`define PTC_UV_NOM    12'h1F4
`define PTC_V_STEP    12'h032
`define PTC_CODE_SPEC 3'h4

`endif

// ==== ptc_pkg.sv ====
/*
 * Types for the protection and trim configuration bank.
 * Assumes nothing of its surroundings.
 */
package ptc_pkg;

   // Register bank state.
   typedef struct packed {
      logic [7:0] zero_cross_detect;
      logic [7:0] per_phase_current_limit;
      logic [7:0] ov;
      logic [7:0] uv;
      logic [7:0] tw;
      logic [7:0] clr;
      logic [7:0] aux;
      logic [7:0] rdata;
      logic       rd_valid;
   } ptc_regs_t;

   // Decoded threshold state.
   typedef struct packed {
      logic signed [5:0]  zcd_steps;
      logic        [11:0] ocl_mv;
      logic        [11:0] ov_mv;
      logic               ov_clamp;
      logic signed [11:0] uv_mv;
      logic               uv_on;
   } ptc_dec_t;

   // Edge detector state.
   typedef struct packed {
      logic prev;
      logic pulse;
   } ptc_edge_t;

endpackage

// ==== ptc_clear_edge.sv ====
/*
 * Rising-edge detector for the over-current status clear bit.
 * Assumes the level input is a register of the same clock.
 */
`timescale 1ns/10ps

module ptc_clear_edge (
   input  wire logic i_clk,    // System clock.
   input  wire logic i_resetn, // Asynchronous reset, active low.
   input  wire logic i_level,  // Stored clear bit.
   output logic      o_pulse   // One-cycle clear pulse.
);

   ptc_pkg::ptc_edge_t q, d;

   // Remember the last level and flag a low-to-high change only.
   always_comb begin
      d       = q;
      d.prev  = i_level;
      d.pulse = i_level & ~q.prev;
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_pulse = q.pulse;

endmodule // ptc_clear_edge

// ==== ptc_thresh_decode.sv ====
/*
 * Decoder from stored codes to threshold values in millivolts.
 * Assumes codes come from registers of the same clock; one cycle latency.
 */
`timescale 1ns/10ps
`include "ptc_defines.svh"

module ptc_thresh_decode (
   input  wire logic               i_clk,      // System clock.
   input  wire logic               i_resetn,   // Asynchronous reset, active low.
   input  wire logic [5:0]         i_zcd,      // Zero-cross trim code.
   input  wire logic [4:0]         i_ocl,      // Floor threshold code.
   input  wire logic [2:0]         i_ov,       // Over-voltage code.
   input  wire logic [2:0]         i_uv,       // Under-voltage code.
   output ptc_pkg::ptc_dec_t       o_dec       // Registered decoded values.
);

   ptc_pkg::ptc_dec_t q, d;
   logic [11:0]       ov_mag;
   logic [11:0]       uv_mag;

   // Decode all codes into threshold values.
   always_comb begin
      d      = q;
      ov_mag = 12'(i_ov[1:0]) * `PTC_V_STEP;
      uv_mag = 12'(i_uv[1:0]) * `PTC_V_STEP;
      // Top bit set gives a positive offset, code 100000 being one step.
      if (i_zcd[5]) begin
         d.zcd_steps = (i_zcd[4:0] == 5'h00) ? 6'sh01 : $signed({1'b0, i_zcd[4:0]});
      end else begin
         d.zcd_steps = -$signed({1'b0, i_zcd[4:0]});
      end
      d.ocl_mv   = `PTC_OCL_BASE + 12'(i_ocl) * `PTC_OCL_STEP;
      d.ov_clamp = (i_ov == `PTC_CODE_SPEC);
      if (d.ov_clamp) begin
         d.ov_mv = `PTC_OV_CLAMP;
      end else if (i_ov[2]) begin
         d.ov_mv = `PTC_OV_NOM - ov_mag;
      end else begin
         d.ov_mv = `PTC_OV_NOM + ov_mag;
      end
      d.uv_on = (i_uv != `PTC_CODE_SPEC);
      // Upper codes raise the level from nominal; code 100 shows no level.
      if (!d.uv_on) begin
         d.uv_mv = 12'sh000;
      end else if (i_uv[2]) begin
         d.uv_mv = -$signed(`PTC_UV_NOM - uv_mag);
      end else begin
         d.uv_mv = -$signed(`PTC_UV_NOM + uv_mag);
      end
   end

   // State register; reset matches all-zero codes.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '{zcd_steps: 6'sh00, ocl_mv: `PTC_OCL_BASE, ov_mv: `PTC_OV_NOM,
                ov_clamp: 1'b0, uv_mv: -$signed(`PTC_UV_NOM), uv_on: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign o_dec = q;

endmodule // ptc_thresh_decode

// ==== ptc_config_regs.sv ====
/*
 * Protection and trim configuration register bank of a multiphase
 * buck controller, with threshold decoding and the status clear pulse.
 * Assumes the two-wire serial engine outside presents byte writes and
 * reads on a simple one-cycle strobe port, and supplies the lock level.
 */
// Operation
// - Six-bit zero-cross trim in bits 5:0, resetting to zero offset.
// - Trim top bit selects positive offset; 0.6 mV steps to 18.6 mV.
// - Five-bit floor threshold in bits 5:1, 215 mV plus 35 mV steps.
// - Floor threshold governs disabling of per-phase current limiting.
// - Floor function enabled only while bit 0 is one; resets disabled.
// - Over-voltage code: 600 mV nominal, plus or minus 50 mV steps.
// - Over-voltage code 100 clamps the threshold at 2.0 V.
// - Under-voltage code: minus 500 mV nominal, shifted in 50 mV steps.
// - Under-voltage code 100 disables under-voltage protection.
// - Eight-bit thermal warning level resetting to 0xFF, 8 mV steps.
// - Status clear only on a zero-to-one change of the clear bit.
// - Clear register stays writable while the lock is set.
// - Ultrasonic timer enabled only by auxiliary bit 3, reset off.
// - Auxiliary bit 2 picks serial settings over fused ones.
// - Auxiliary bit 1 picks the current-limit trigger comparison.
// - Host changes these settings over the serial port during operation.
`timescale 1ns/10ps
`include "ptc_defines.svh"

module ptc_config_regs (
   input  wire logic               i_clk,                 // System clock, 100 MHz.
   input  wire logic               i_resetn,              // Asynchronous reset, active low.
   input  wire logic               i_wr_en,               // Write strobe from serial engine.
   input  wire logic               i_rd_en,               // Read strobe from serial engine.
   input  wire logic [7:0]         i_addr,                // Register address.
   input  wire logic [7:0]         i_wdata,               // Write data.
   input  wire logic               i_lock,                // Register lock level.
   output logic      [7:0]         o_rdata,               // Read data.
   output logic                    o_rd_valid,            // Read data valid pulse.
   output logic signed [5:0]       o_zero_cross_steps,    // Trim in 0.6 mV steps.
   output logic      [11:0]        o_ocl_floor_voltage,   // Floor threshold, mV.
   output logic                    o_ocl_floor_on,        // Floor function enable.
   output logic      [11:0]        o_overvoltage_mv,      // Over-voltage threshold, mV.
   output logic                    o_overvoltage_clamped, // Threshold clamped high.
   output logic signed [11:0]      o_undervoltage_mv,     // Under-voltage threshold, mV.
   output logic                    o_undervoltage_on,     // Under-voltage protection on.
   output logic      [7:0]         o_thermal_warning,     // Warning level, 8 mV codes.
   output logic                    o_overcurrent_clear,   // Status clear pulse.
   output logic                    o_ultrasonic_timer_on, // Ultrasonic timer enable.
   output logic                    o_settings_serial,     // Serial settings selected.
   output logic                    o_current_limit_event_trigger_select  // Current-limit trigger select.
);

   ////////////////////////////////////////////////////////////////////////
   // State.

   ptc_pkg::ptc_regs_t q, d;
   ptc_pkg::ptc_dec_t  dec;
   logic               clr_pulse;

   ////////////////////////////////////////////////////////////////////////
   // Register access.

   // Writes store implemented bits only; the lock holds all but clear.
   always_comb begin
      d          = q;
      d.rd_valid = i_rd_en;
      if (i_wr_en) begin
         case (i_addr)
            `PTC_ADDR_ZCD: begin
               if (!i_lock) begin
                  d.zero_cross_detect = i_wdata & `PTC_MASK_ZCD;
               end
            end
            `PTC_ADDR_OCL: begin
               if (!i_lock) begin
                  d.per_phase_current_limit = i_wdata & `PTC_MASK_OCL;
               end
            end
            `PTC_ADDR_OV: begin
               if (!i_lock) begin
                  d.ov = i_wdata & `PTC_MASK_OV;
               end
            end
            `PTC_ADDR_UV: begin
               if (!i_lock) begin
                  d.uv = i_wdata & `PTC_MASK_UV;
               end
            end
            `PTC_ADDR_TW: begin
               if (!i_lock) begin
                  d.tw = i_wdata & `PTC_MASK_TW;
               end
            end
            `PTC_ADDR_CLR: begin
               d.clr = i_wdata & `PTC_MASK_CLR;
            end
            `PTC_ADDR_AUX: begin
               if (!i_lock) begin
                  d.aux = i_wdata & `PTC_MASK_AUX;
               end
            end
            default: begin
            end
         endcase
      end
      // Reads return stored values; unmapped addresses read zero.
      if (i_rd_en) begin
         case (i_addr)
            `PTC_ADDR_ZCD: begin
               d.rdata = q.zero_cross_detect;
            end
            `PTC_ADDR_OCL: begin
               d.rdata = q.per_phase_current_limit;
            end
            `PTC_ADDR_OV: begin
               d.rdata = q.ov;
            end
            `PTC_ADDR_UV: begin
               d.rdata = q.uv;
            end
            `PTC_ADDR_TW: begin
               d.rdata = q.tw;
            end
            `PTC_ADDR_CLR: begin
               d.rdata = q.clr;
            end
            `PTC_ADDR_AUX: begin
               d.rdata = q.aux;
            end
            default: begin
               d.rdata = `PTC_RST_ZERO;
            end
         endcase
      end
   end

   // State register with documented reset values.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q.zero_cross_detect      <= `PTC_RST_ZERO;
         q.per_phase_current_limit      <= `PTC_RST_ZERO;
         q.ov       <= `PTC_RST_ZERO;
         q.uv       <= `PTC_RST_ZERO;
         q.tw       <= `PTC_RST_TW;
         q.clr      <= `PTC_RST_ZERO;
         q.aux      <= `PTC_RST_ZERO;
         q.rdata    <= `PTC_RST_ZERO;
         q.rd_valid <= 1'b0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoding and clear pulse.

   // Codes become registered threshold values one cycle later.
   ptc_thresh_decode u_decode (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_zcd    (q.zero_cross_detect[5:0]),
      .i_ocl    (q.per_phase_current_limit[5:1]),
      .i_ov     (q.ov[2:0]),
      .i_uv     (q.uv[2:0]),
      .o_dec    (dec)
   );

   // Clear bit edge detector keeps its own copy of the previous bit.
   ptc_clear_edge u_clear_edge (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_level  (q.clr[`PTC_CLR_BIT]),
      .o_pulse  (clr_pulse)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from flip-flops.

   // Register and decoder state drive the analogue controls directly.
   assign o_rdata               = q.rdata;
   assign o_rd_valid            = q.rd_valid;
   assign o_zero_cross_steps    = dec.zcd_steps;
   assign o_ocl_floor_voltage   = dec.ocl_mv;
   assign o_ocl_floor_on        = q.per_phase_current_limit[`PTC_OCL_EN];
   assign o_overvoltage_mv      = dec.ov_mv;
   assign o_overvoltage_clamped = dec.ov_clamp;
   assign o_undervoltage_mv     = dec.uv_mv;
   assign o_undervoltage_on     = dec.uv_on;
   assign o_thermal_warning     = q.tw;
   assign o_overcurrent_clear   = clr_pulse;
   assign o_ultrasonic_timer_on = q.aux[`PTC_AUX_SONIC];
   assign o_settings_serial     = q.aux[`PTC_AUX_SRC];
   assign o_current_limit_event_trigger_select = q.aux[`PTC_AUX_CURRENT_LIMIT_EVENT];

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // Unlocked write to a given address.
   sequence s_wr(logic [7:0] a);
      i_wr_en && !i_lock && (i_addr == a);
   endsequence

   // Clear bit written to one while stored zero.
   sequence s_clr_rise;
      i_wr_en && (i_addr == `PTC_ADDR_CLR) && i_wdata[0] && !q.clr[0];
   endsequence

   // A trim write lands in its register one cycle later.
   a_zcd_trim_store: assert property (
      s_wr(`PTC_ADDR_ZCD) ##1 1'b1 |-> q.zero_cross_detect == ($past(i_wdata) & 8'h3F))
      else $error("zero-cross trim not stored");

   // Clear top bit gives negative steps.
   a_zcd_sign_dir: assert property (
      q.zero_cross_detect[5] == 1'b0 |=> o_zero_cross_steps == -$signed({1'b0, $past(q.zero_cross_detect[4:0])}))
      else $error("negative trim decoded wrong");

   // Set top bit gives positive steps.
   a_zcd_pos_dir: assert property (
      q.zero_cross_detect[5] && q.zero_cross_detect[4:0] != 5'h00 |=> o_zero_cross_steps > 6'sh00)
      else $error("positive trim decoded wrong");

   // Floor value follows its code.
   a_ocl_floor_val: assert property (
      1'b1 |=> o_ocl_floor_voltage == 12'h0D7 + 12'($past(q.per_phase_current_limit[5:1])) * 12'h023)
      else $error("floor threshold value wrong");

   // Floor enable follows bit 0.
   a_ocl_floor_en: assert property (
      s_wr(`PTC_ADDR_OCL) |=> o_ocl_floor_on == $past(i_wdata[0]))
      else $error("floor enable not following write");

   // Top floor code reaches 1.3 V.
   a_ocl_floor_top: assert property (
      q.per_phase_current_limit[5:1] == 5'h1F |=> o_ocl_floor_voltage == 12'h514)
      else $error("floor top code not 1.3 V");

   // Low over-voltage codes raise the level.
   a_ov_offset_add: assert property (
      q.ov[2] == 1'b0 |=> o_overvoltage_mv == 12'h258 + 12'($past(q.ov[1:0])) * 12'h032)
      else $error("over-voltage raise wrong");

   // Code 111 lowers the level by 150 mV.
   a_ov_offset_sub: assert property (
      q.ov[2:0] == 3'h7 |=> o_overvoltage_mv == 12'h1C2)
      else $error("over-voltage lower wrong");

   // Code 100 clamps the level high.
   a_ov_clamp_two: assert property (
      q.ov[2:0] == 3'h4 |=> o_overvoltage_mv == 12'h7D0 && o_overvoltage_clamped)
      else $error("over-voltage clamp missing");

   // Code 011 lowers the level by 150 mV.
   a_uv_shift_val: assert property (
      q.uv[2:0] == 3'h3 |=> o_undervoltage_mv == -12'sh28A)
      else $error("under-voltage shift wrong");

   // Code 100 turns protection off.
   a_uv_disable_on: assert property (
      1'b1 |=> o_undervoltage_on == ($past(q.uv[2:0]) != 3'h4))
      else $error("under-voltage disable wrong");

   // Warning level follows its write.
   a_tw_level_store: assert property (
      s_wr(`PTC_ADDR_TW) |=> o_thermal_warning == $past(i_wdata))
      else $error("thermal warning not stored");

   // A rising clear bit pulses two cycles on.
   a_clear_rise_pulse: assert property (
      s_clr_rise |-> ##2 o_overcurrent_clear)
      else $error("clear pulse missing");

   // No pulse without a rising bit.
   a_clear_only_edge: assert property (
      o_overcurrent_clear |-> $past(q.clr[0]) && !$past(q.clr[0], 2))
      else $error("clear pulse without rising edge");

   // The clear register ignores the lock.
   a_clear_while_lock: assert property (
      i_lock && i_wr_en && i_addr == `PTC_ADDR_CLR |=> q.clr == ($past(i_wdata) & 8'h01))
      else $error("clear register blocked by lock");

   // The lock freezes the auxiliary and over-voltage registers.
   a_lock_holds_aux: assert property (
      i_lock && !(i_wr_en && i_addr == `PTC_ADDR_CLR) |=> $stable(q.aux) && $stable(q.ov))
      else $error("locked register changed");

   // Auxiliary selects follow their bits.
   a_aux_bit_sel: assert property (
      s_wr(`PTC_ADDR_AUX) |=> o_ultrasonic_timer_on == $past(i_wdata[3])
         && o_settings_serial == $past(i_wdata[2]) && o_current_limit_event_trigger_select == $past(i_wdata[1]))
      else $error("auxiliary selects wrong");

   // Reserved voltage bits read zero.
   a_read_reserved: assert property (
      i_rd_en && (i_addr == `PTC_ADDR_OV || i_addr == `PTC_ADDR_UV) |=> o_rd_valid && o_rdata[7:3] == 5'h00)
      else $error("reserved bits read nonzero");

   // Code 100000 gives the smallest positive step.
   a_zcd_pos_one: assert property (
      q.zero_cross_detect[5:0] == 6'h20 |=> o_zero_cross_steps == 6'sh01)
      else $error("smallest positive trim wrong");

   // Code 000 keeps the nominal over-voltage level.
   a_ov_nominal_lvl: assert property (
      q.ov[2:0] == 3'h0 |=> o_overvoltage_mv == `PTC_OV_NOM && !o_overvoltage_clamped)
      else $error("over-voltage nominal wrong");

   // Code 111 raises the under-voltage level by 150 mV.
   a_uv_raise_val: assert property (
      q.uv[2:0] == 3'h7 |=> o_undervoltage_mv == -12'sh15E)
      else $error("under-voltage raise wrong");

   // The clear pulse lasts one cycle.
   a_clear_one_cycle: assert property (
      o_overcurrent_clear |=> !o_overcurrent_clear)
      else $error("clear pulse too long");

   // Rewriting a set clear bit gives no pulse.
   a_clear_no_repeat: assert property (
      i_wr_en && i_addr == `PTC_ADDR_CLR && q.clr[0] |-> ##2 !o_overcurrent_clear)
      else $error("clear pulse without change");

   // The lock freezes trim and warning level.
   a_lock_holds_trim: assert property (
      i_lock |=> $stable(q.zero_cross_detect) && $stable(q.tw))
      else $error("locked trim changed");

   // Every read strobe gives one valid pulse.
   a_read_valid_pulse: assert property (
      1'b1 |=> o_rd_valid == $past(i_rd_en))
      else $error("read valid pulse wrong");

   // A warning level read returns the stored code.
   a_read_tw_data: assert property (
      i_rd_en && i_addr == `PTC_ADDR_TW |=> o_rdata == $past(q.tw))
      else $error("warning level read wrong");

   // Unmapped addresses read zero.
   a_read_unmapped: assert property (
      i_rd_en && (i_addr < `PTC_ADDR_ZCD || i_addr > `PTC_ADDR_AUX) |=> o_rdata == 8'h00)
      else $error("unmapped read nonzero");

endmodule // ptc_config_regs

// ==== ptc_host_model.sv ====
/*
 * Host model: byte writes and reads on the bank's strobe port.
 * Assumes the bank's clock; it drives just after each falling edge.
 */
`timescale 1ns/10ps

module ptc_host_model (
   input  wire logic       i_clk,      // System clock.
   input  wire logic [7:0] i_rdata,    // Read data from the bank.
   input  wire logic       i_rd_valid, // Read data valid pulse.
   output logic            o_wr_en,    // Write strobe.
   output logic            o_rd_en,    // Read strobe.
   output logic [7:0]      o_addr,     // Register address.
   output logic [7:0]      o_wdata     // Write data.
);
   // Idle lines show a pattern, never a stale value.
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 8'hA5;
      o_wdata = 8'h5A;
   end

   ////////////////////////////////////////////////////////////
   // One byte write; released lines turn to their inverse.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr_en = 1'b1;
      o_addr  = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask

   // One byte read; waits a bounded time for the valid pulse.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(negedge i_clk);
      o_rd_en = 1'b1;
      o_addr  = a;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      o_addr  = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         if (i_rd_valid === 1'b1) begin
            ok = 1'b1;
            d = i_rdata;
         end else begin
            @(negedge i_clk);
         end
      end
   endtask
endmodule // ptc_host_model

// ==== test_protection_trim_config_regs.sv ====
/*
 * Self-checking bench for the protection and trim register bank.
 * Assumes the host model drives the port; the bench drives lock and reset.
 */
`timescale 1ns/10ps
`include "ptc_defines.svh"

module test_protection_trim_config_regs;
   logic               i_clk;
   logic               i_resetn;
   logic               i_lock;
   logic               wr_en;
   logic               rd_en;
   logic [7:0]         addr;
   logic [7:0]         wdata;
   logic [7:0]         rdata;
   logic               rd_valid;
   logic signed [5:0]  zero_cross_detect;
   logic [11:0]        ocl_mv;
   logic               ocl_on;
   logic [11:0]        ov_mv;
   logic               ov_clamp;
   logic signed [11:0] uv_mv;
   logic               uv_on;
   logic [7:0]         tw;
   logic               clr;
   logic               sonic;
   logic               serial;
   logic               current_limit_event;
   int                 mismatches;
   int                 compares;

   // Clock at 100 MHz.
   initial i_clk = 1'b0;
   always #5 i_clk = ~i_clk;

   ptc_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

   ptc_config_regs u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_lock(i_lock),
      .o_rdata(rdata), .o_rd_valid(rd_valid), .o_zero_cross_steps(zero_cross_detect),
      .o_ocl_floor_voltage(ocl_mv), .o_ocl_floor_on(ocl_on), .o_overvoltage_mv(ov_mv),
      .o_overvoltage_clamped(ov_clamp), .o_undervoltage_mv(uv_mv),
      .o_undervoltage_on(uv_on), .o_thermal_warning(tw), .o_overcurrent_clear(clr),
      .o_ultrasonic_timer_on(sonic), .o_settings_serial(serial),
      .o_current_limit_event_trigger_select(current_limit_event));

   ////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", what, e, g);
      end
   endtask

   // Reads a register and compares it; a missing valid pulse ends the run.
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      u_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR read valid expected 1 seen %0b", ok);
         close_out();
      end else begin
         chk("read data", {8'h00, e}, {8'h00, d});
      end
   endtask

   // Writes a register and lets the decoded values settle.
   task automatic wrs(input logic [7:0] a, input logic [7:0] d);
      u_host.wr(a, d);
      repeat (3) @(negedge i_clk);
   endtask

   // Writes the clear register and counts pulses over the next six cycles.
   task automatic clr_w(input logic [7:0] d, input logic [15:0] e);
      int          n;
      logic [15:0] cnt;
      cnt = 16'h0000;
      u_host.wr(`PTC_ADDR_CLR, d);
      for (n = 0; n < 6; n++) begin
         cnt = cnt + {15'h0000, clr};
         @(negedge i_clk);
      end
      chk("clear pulses", e, cnt);
   endtask

   ////////////////////////////////////////////////////////////
   // Reset values of registers and decoded outputs.
   task automatic t_reset();
      rdchk(`PTC_ADDR_ZCD, 8'h00);
      rdchk(`PTC_ADDR_OCL, 8'h00);
      rdchk(`PTC_ADDR_OV, 8'h00);
      rdchk(`PTC_ADDR_UV, 8'h00);
      rdchk(`PTC_ADDR_TW, 8'hFF);
      rdchk(`PTC_ADDR_AUX, 8'h00);
      chk("floor mv", 16'h00D7, {4'h0, ocl_mv});
      chk("ov mv", 16'h0258, {4'h0, ov_mv});
      chk("uv mv", 16'h0E0C, {4'h0, uv_mv});
      chk("aux outs", 16'h0000, {13'h0000, sonic, serial, current_limit_event});
      chk("trim steps", 16'h0000, {10'h000, zero_cross_detect});
      chk("reset flags", 16'h0004, {12'h000, ov_clamp, uv_on, ocl_on, clr});
      $display("Test reset values done");
   endtask

   // Trim codes at both extremes, the smallest steps and reserved bits.
   task automatic t_zcd();
      logic [7:0] c [5] = '{8'h3F, 8'h20, 8'h01, 8'h1F, 8'hE5};
      logic [5:0] s [5] = '{6'h1F, 6'h01, 6'h3F, 6'h21, 6'h05};
      for (int i = 0; i < 5; i++) begin
         wrs(`PTC_ADDR_ZCD, c[i]);
         chk("trim steps", {10'h000, s[i]}, {10'h000, zero_cross_detect});
         rdchk(`PTC_ADDR_ZCD, c[i] & 8'h3F);
      end
      $display("Test trim done");
   endtask

   // Floor threshold codes and the enable bit.
   task automatic t_ocl();
      logic [7:0] c [3] = '{8'h3F, 8'h02, 8'hC3};
      for (int i = 0; i < 3; i++) begin
         wrs(`PTC_ADDR_OCL, c[i]);
         chk("floor mv", {4'h0, `PTC_OCL_BASE + `PTC_OCL_STEP * {7'h00, c[i][5:1]}}, {4'h0, ocl_mv});
         chk("floor on", {15'h0000, c[i][0]}, {15'h0000, ocl_on});
         rdchk(`PTC_ADDR_OCL, c[i] & 8'h3F);
      end
      $display("Test floor done");
   endtask

   // Every over- and under-voltage code, reserved bits set.
   task automatic t_ov_uv();
      logic [11:0] k;
      logic [11:0] e;
      for (int i = 0; i < 8; i++) begin
         k = `PTC_V_STEP * {10'h000, 2'(i)};
         wrs(`PTC_ADDR_OV, 8'hF8 | 8'(i));
         e = (i == 4) ? `PTC_OV_CLAMP : (i > 4) ? `PTC_OV_NOM - k : `PTC_OV_NOM + k;
         chk("ov mv", {4'h0, e}, {4'h0, ov_mv});
         chk("ov clamp", {15'h0000, i == 4}, {15'h0000, ov_clamp});
         wrs(`PTC_ADDR_UV, 8'hF8 | 8'(i));
         e = (i == 4) ? 12'h000 : (i > 4) ? k - `PTC_UV_NOM : 12'h000 - `PTC_UV_NOM - k;
         chk("uv mv", {4'h0, e}, {4'h0, uv_mv});
         chk("uv on", {15'h0000, i != 4}, {15'h0000, uv_on});
         rdchk(`PTC_ADDR_UV, 8'(i));
      end
      $display("Test voltage codes done");
   endtask

   // Thermal warning level; output checked at zero, read back at 0x80.
   task automatic t_tw();
      wrs(`PTC_ADDR_TW, 8'h00);
      chk("warning", 16'h0000, {8'h00, tw});
      wrs(`PTC_ADDR_TW, 8'h80);
      rdchk(`PTC_ADDR_TW, 8'h80);
      $display("Test thermal done");
   endtask

   // Clear pulse on rising bit only; clear stays writable under lock.
   task automatic t_clear();
      clr_w(8'h01, 16'h0001);
      clr_w(8'hFF, 16'h0000);
      rdchk(`PTC_ADDR_CLR, 8'h01);
      clr_w(8'h00, 16'h0000);
      i_lock = 1'b1;
      clr_w(8'h01, 16'h0001);
      wrs(`PTC_ADDR_AUX, 8'h0E);
      rdchk(`PTC_ADDR_AUX, 8'h00);
      i_lock = 1'b0;
      clr_w(8'h00, 16'h0000);
      $display("Test clear done");
   endtask

   // Auxiliary selects one at a time, reserved bits, unmapped places.
   task automatic t_aux();
      logic [7:0] c [4] = '{8'h08, 8'h04, 8'h02, 8'hF1};
      for (int i = 0; i < 4; i++) begin
         wrs(`PTC_ADDR_AUX, c[i]);
         chk("aux outs", {13'h0000, c[i][3:1]}, {13'h0000, sonic, serial, current_limit_event});
         rdchk(`PTC_ADDR_AUX, c[i] & 8'h0E);
      end
      wrs(8'h54, 8'hFF);
      rdchk(8'h54, 8'h00);
      rdchk(8'h4C, 8'h00);
      $display("Test auxiliary done");
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence: reset for six cycles, then every scenario.
   initial begin
      mismatches = 0;
      compares = 0;
      i_resetn = 1'b0;
      i_lock = 1'b0;
      repeat (6) @(negedge i_clk);
      i_resetn = 1'b1;
      t_reset();
      t_zcd();
      t_ocl();
      t_ov_uv();
      t_tw();
      t_clear();
      t_aux();
      close_out();
   end
endmodule // test_protection_trim_config_regs
